// ===== ecidl_delay_timer.sv
// Retriggerable delay timer that limits how often the alert is raised
`timescale 1ns/1ps
module ecidl_delay_timer #(
  parameter int CYCLES = 5000
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic reset_i,
  // Control
  input  wire logic start_i,
  // Status
  output logic      running_o
);
  import ecidl_pkg::*;
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES);

  ecidl_tmr_state_t state;
  ecidl_tmr_state_t next_state;
  logic [W-1:0]     count;
  logic [W-1:0]     next_count;

  always_comb
  begin
    next_state = state;
    next_count = count;
    case (state)
      ECIDL_TMR_IDLE:
      begin
        if (start_i)
        begin
          next_state = ECIDL_TMR_RUN;
          next_count = LOAD;
        end
      end
      ECIDL_TMR_RUN:
      begin
        if (start_i)
          next_count = LOAD;
        else if (count == W'(1))
          next_state = ECIDL_TMR_IDLE;
        else
          next_count = count - W'(1);
      end
      default:
        next_state = ECIDL_TMR_IDLE;
    endcase
  end

  // Power-on leaves the timer idle
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      state <= ECIDL_TMR_IDLE;
      count <= '0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign running_o = (state == ECIDL_TMR_RUN);
endmodule : ecidl_delay_timer

// ===== ecidl_event_capture.sv
// Event capture, alert delay and sleep protection
// Notes on behaviour
// - Host clear releases alert, starts delay timer
// - Events during delay set flags, no alert
// - Timer end with pending flag drives alert
// - Timer end with no flags keeps alert released
// - Flag and enable registers readable at any time
// - Sleep only with wake source and clear flags
// - Flags clear on written one, zero ignored
// - Summary bits show pin, bus, system pending
// - System flags: restart 4, overtemp 2, serial 1
// - Restart flag cleared by undervoltage forced sleep
// - First normal entry clears normal entry flag
// - Bus flags: frame 5, idle 4, fault 1, wakeup 0
// - Idle flag after silence, zero while active
// - Fault only in normal, active bus mode
// - Pin flags: rise bit 1, fall bit 0
// - System enables: overtemp bit 2, serial bit 1
// - Restart and frame error always captured
// - Other flags set only when enabled, count pending
// - Offline bus mode drives alert when pending
`timescale 1ns/1ps
`include "ecidl_regs.svh"
module ecidl_event_capture #(
  parameter int DELAY_CYCLES   = `ECIDL_EVENT_DELAY_CYC,
  parameter int SILENCE_CYCLES = `ECIDL_SILENCE_CYC
) (
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                reset_i,
  // Register port
  input  wire ecidl_pkg::ecidl_addr_t reg_addr_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  input  wire ecidl_pkg::ecidl_byte_t reg_wdata_i,
  output ecidl_pkg::ecidl_byte_t   reg_rdata_o,
  // Mode state and commands
  input  wire logic                normal_mode_i,
  input  wire logic                bus_active_mode_i,
  input  wire logic                bus_offline_i,
  input  wire logic [1:0]          bus_mode_field_i,
  input  wire logic                mode_cmd_i,
  input  wire logic [2:0]          mode_control_field_i,
  input  wire logic                normal_entered_i,
  input  wire logic                uv_forced_sleep_i,
  // Event sources
  input  wire logic                overtemp_i,
  input  wire logic                serial_fault_i,
  input  wire logic                frame_error_i,
  input  wire logic                bus_wakeup_i,
  input  wire logic                bus_activity_i,
  input  wire logic                txd_clamp_i,
  input  wire logic                vcc_uv_i,
  input  wire logic                wake_pin_i,
  // Outputs
  output logic                     rx_alert_n_o,
  output logic                     enter_sleep_o,
  output logic                     enter_standby_o,
  output logic                     normal_entry_flag_o
);
  import ecidl_pkg::*;
  localparam int SW = $clog2(SILENCE_CYCLES + 1);
  localparam logic [SW-1:0] SILENCE_LAST = SW'(SILENCE_CYCLES - 1);

  function automatic ecidl_byte_t w1c_update(input ecidl_byte_t flags,
                                             input ecidl_byte_t set,
                                             input logic        clr,
                                             input ecidl_byte_t wdata,
                                             input ecidl_byte_t mask);
    ecidl_byte_t kill;
    kill = clr ? wdata : 8'h00;
    return ((flags & ~kill) | set) & mask;
  endfunction : w1c_update

  ecidl_byte_t sys_flags, bus_flags, pin_flags;
  ecidl_byte_t sys_en, bus_en, pin_en;
  ecidl_byte_t next_sys_flags, next_bus_flags, next_pin_flags;
  ecidl_byte_t next_sys_en, next_bus_en, next_pin_en;
  ecidl_byte_t sys_set, bus_set, pin_set;
  ecidl_byte_t global_summary, next_rdata;
  logic [SW-1:0] silence_count, next_silence_count;
  logic        silence_hit, pin_rise, pin_fall, timer_running;
  logic        wr_sys, wr_bus, wr_pin, clear_event, pending, wake_source;
  logic        next_rx_alert_n, next_sleep, next_standby, next_normal_entry;

  ecidl_delay_timer #(
    .CYCLES    (DELAY_CYCLES)
  ) u_timer (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .start_i   (clear_event),
    .running_o (timer_running)
  );

  ecidl_pin_edge u_edge (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .pin_i     (wake_pin_i),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  // Write strobes and event detection
  always_comb
  begin
    wr_sys = reg_wr_i && (reg_addr_i == `ECIDL_ADDR_SYS_FLAGS);
    wr_bus = reg_wr_i && (reg_addr_i == `ECIDL_ADDR_BUS_FLAGS);
    wr_pin = reg_wr_i && (reg_addr_i == `ECIDL_ADDR_PIN_FLAGS);
    clear_event = (wr_sys && ((reg_wdata_i & sys_flags) != 8'h00))
               || (wr_bus && ((reg_wdata_i & bus_flags) != 8'h00))
               || (wr_pin && ((reg_wdata_i & pin_flags) != 8'h00));
    silence_hit = !bus_activity_i && (silence_count == SILENCE_LAST);
    sys_set = 8'h00;
    bus_set = 8'h00;
    pin_set = 8'h00;
    sys_set[`ECIDL_SYS_OVERTEMP_BIT] = overtemp_i && sys_en[`ECIDL_SYS_OVERTEMP_BIT];
    sys_set[`ECIDL_SYS_SERIAL_BIT] = serial_fault_i && sys_en[`ECIDL_SYS_SERIAL_BIT];
    bus_set[`ECIDL_BUS_FRAME_BIT] = frame_error_i;
    bus_set[`ECIDL_BUS_IDLE_BIT] = silence_hit && bus_en[`ECIDL_BUS_IDLE_BIT];
    bus_set[`ECIDL_BUS_FAULT_BIT] = bus_en[`ECIDL_BUS_FAULT_BIT] && normal_mode_i
      && bus_active_mode_i
      && (txd_clamp_i || (vcc_uv_i && bus_mode_field_i == `ECIDL_BUS_MODE_UV));
    bus_set[`ECIDL_BUS_WAKEUP_BIT] = bus_wakeup_i && bus_en[`ECIDL_BUS_WAKEUP_BIT];
    pin_set[`ECIDL_PIN_RISE_BIT] = pin_rise && pin_en[`ECIDL_PIN_RISE_BIT];
    pin_set[`ECIDL_PIN_FALL_BIT] = pin_fall && pin_en[`ECIDL_PIN_FALL_BIT];
    pending = (sys_flags | bus_flags | pin_flags) != 8'h00;
    wake_source = bus_en[`ECIDL_BUS_WAKEUP_BIT] || (pin_en & `ECIDL_PIN_EN_MASK) != 8'h00;
    global_summary = 8'h00;
    global_summary[`ECIDL_GLB_PIN_BIT] = pin_flags != 8'h00;
    global_summary[`ECIDL_GLB_BUS_BIT] = bus_flags != 8'h00;
    global_summary[`ECIDL_GLB_SYS_BIT] = sys_flags != 8'h00;
  end

  // Flag and enable next values
  always_comb
  begin
    next_silence_count = bus_activity_i ? '0
      : (silence_count == SILENCE_LAST) ? silence_count : silence_count + SW'(1);
    // Set wins over a host clear in the same cycle
    next_sys_flags = w1c_update(sys_flags, sys_set, wr_sys, reg_wdata_i,
                                `ECIDL_SYS_FLAG_MASK);
    next_bus_flags = w1c_update(bus_flags, bus_set, wr_bus, reg_wdata_i,
                                `ECIDL_BUS_FLAG_MASK);
    next_pin_flags = w1c_update(pin_flags, pin_set, wr_pin, reg_wdata_i,
                                `ECIDL_PIN_FLAG_MASK);
    if (bus_activity_i)
      next_bus_flags[`ECIDL_BUS_IDLE_BIT] = 1'b0;
    next_sys_en = sys_en;
    next_bus_en = bus_en;
    next_pin_en = pin_en;
    if (reg_wr_i && reg_addr_i == `ECIDL_ADDR_SYS_EN)
      next_sys_en = reg_wdata_i & `ECIDL_SYS_EN_MASK;
    else if (reg_wr_i && reg_addr_i == `ECIDL_ADDR_BUS_EN)
      next_bus_en = reg_wdata_i & `ECIDL_BUS_EN_MASK;
    else if (reg_wr_i && reg_addr_i == `ECIDL_ADDR_PIN_EN)
      next_pin_en = reg_wdata_i & `ECIDL_PIN_EN_MASK;
    if (uv_forced_sleep_i)
    begin
      next_sys_flags = 8'h00;
      next_bus_flags = 8'h00;
      next_pin_flags = 8'h00;
      next_bus_en = bus_en | `ECIDL_UV_BUS_EN;
      next_pin_en = `ECIDL_UV_PIN_EN;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      sys_flags     <= `ECIDL_SYS_FLAG_RESET;
      bus_flags     <= `ECIDL_BUS_FLAG_RESET;
      pin_flags     <= `ECIDL_PIN_FLAG_RESET;
      sys_en        <= `ECIDL_EN_RESET;
      bus_en        <= `ECIDL_EN_RESET;
      pin_en        <= `ECIDL_EN_RESET;
      silence_count <= '0;
    end
    else
    begin
      sys_flags     <= next_sys_flags;
      bus_flags     <= next_bus_flags;
      pin_flags     <= next_pin_flags;
      sys_en        <= next_sys_en;
      bus_en        <= next_bus_en;
      pin_en        <= next_pin_en;
      silence_count <= next_silence_count;
    end
  end

  // Read data, alert pin and mode decisions
  always_comb
  begin
    next_rdata = reg_rdata_o;
    if (reg_rd_i)
    begin
      if (reg_addr_i == `ECIDL_ADDR_SYS_EN)
        next_rdata = sys_en;
      else if (reg_addr_i == `ECIDL_ADDR_BUS_EN)
        next_rdata = bus_en;
      else if (reg_addr_i == `ECIDL_ADDR_PIN_EN)
        next_rdata = pin_en;
      else if (reg_addr_i == `ECIDL_ADDR_GLOBAL)
        next_rdata = global_summary;
      else if (reg_addr_i == `ECIDL_ADDR_SYS_FLAGS)
        next_rdata = sys_flags;
      else if (reg_addr_i == `ECIDL_ADDR_BUS_FLAGS)
        next_rdata = bus_flags;
      else if (reg_addr_i == `ECIDL_ADDR_PIN_FLAGS)
        next_rdata = pin_flags;
      else
        next_rdata = 8'h00;
    end
    next_rx_alert_n = !(bus_offline_i && pending && !timer_running && !clear_event);
    next_sleep   = 1'b0;
    next_standby = 1'b0;
    if (mode_cmd_i && mode_control_field_i == `ECIDL_MC_SLEEP)
    begin
      next_sleep   = wake_source && !pending;
      next_standby = !(wake_source && !pending);
    end
    next_normal_entry = normal_entry_flag_o && !normal_entered_i;
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      reg_rdata_o         <= 8'h00;
      rx_alert_n_o        <= 1'b1;
      enter_sleep_o       <= 1'b0;
      enter_standby_o     <= 1'b0;
      normal_entry_flag_o <= 1'b1;
    end
    else
    begin
      reg_rdata_o         <= next_rdata;
      rx_alert_n_o        <= next_rx_alert_n;
      enter_sleep_o       <= next_sleep;
      enter_standby_o     <= next_standby;
      normal_entry_flag_o <= next_normal_entry;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence s_timer_end;
    $fell(timer_running);
  endsequence

  a_clear_releases: assert property (clear_event |=> rx_alert_n_o)
    else $error("Alert not released after clear");
  a_timer_blocks: assert property (timer_running |=> rx_alert_n_o)
    else $error("Alert driven while delay runs");
  a_expiry_alerts: assert property (s_timer_end ##0 (pending && bus_offline_i
    && !clear_event) |=> !rx_alert_n_o)
    else $error("No alert at timer end with pending event");
  a_expiry_quiet: assert property (s_timer_end ##0 !pending |=> rx_alert_n_o)
    else $error("Alert at timer end without pending event");
  a_read_flags: assert property (reg_rd_i && reg_addr_i == `ECIDL_ADDR_SYS_FLAGS
    |=> reg_rdata_o == $past(sys_flags))
    else $error("System flags read back wrong");
  a_sleep_choice: assert property (mode_cmd_i && mode_control_field_i == `ECIDL_MC_SLEEP
    |=> (enter_sleep_o == $past(wake_source && !pending)) && (enter_standby_o != enter_sleep_o))
    else $error("Wrong sleep or standby decision");
  a_zero_keeps: assert property (wr_pin && reg_wdata_i == 8'h00 && !uv_forced_sleep_i
    |=> (pin_flags & $past(pin_flags)) == $past(pin_flags))
    else $error("Writing zero cleared a flag");
  a_summary_pin: assert property (reg_rd_i && reg_addr_i == `ECIDL_ADDR_GLOBAL
    |=> reg_rdata_o[`ECIDL_GLB_PIN_BIT] == ($past(pin_flags) != 8'h00))
    else $error("Summary pin bit wrong");
  a_uv_restart: assert property (uv_forced_sleep_i |=> !sys_flags[`ECIDL_SYS_RESTART_BIT])
    else $error("Restart flag kept after forced sleep");
  a_normal_entry: assert property (normal_entered_i |=> !normal_entry_flag_o)
    else $error("Normal entry flag not cleared");
  a_idle_active: assert property (bus_activity_i |=> !bus_flags[`ECIDL_BUS_IDLE_BIT])
    else $error("Idle flag set while bus active");
  a_fault_gate: assert property ($rose(bus_flags[`ECIDL_BUS_FAULT_BIT])
    |-> $past(normal_mode_i && bus_active_mode_i))
    else $error("Fault captured outside active normal mode");
  a_reserved_zero: assert property (reg_rd_i && reg_addr_i == `ECIDL_ADDR_PIN_FLAGS
    |=> reg_rdata_o[7:2] == 6'h00)
    else $error("Reserved pin bits not zero");
  a_timer_starts: assert property (clear_event |=> timer_running)
    else $error("Delay timer not started by clear");
  a_frame_always: assert property (frame_error_i && !uv_forced_sleep_i
    |=> bus_flags[`ECIDL_BUS_FRAME_BIT])
    else $error("Frame error not captured");
  a_overtemp_gate: assert property ($rose(sys_flags[`ECIDL_SYS_OVERTEMP_BIT])
    |-> $past(sys_en[`ECIDL_SYS_OVERTEMP_BIT]))
    else $error("Overtemp captured while disabled");
  a_sys_reserved: assert property ((sys_flags & ~`ECIDL_SYS_FLAG_MASK) == 8'h00)
    else $error("Reserved system flag set");
  a_bus_reserved: assert property ((bus_flags & ~`ECIDL_BUS_FLAG_MASK) == 8'h00)
    else $error("Reserved bus flag set");
  a_pin_rise: assert property (pin_rise && pin_en[`ECIDL_PIN_RISE_BIT] && !uv_forced_sleep_i
    |=> pin_flags[`ECIDL_PIN_RISE_BIT])
    else $error("Rising pin edge not captured");
endmodule : ecidl_event_capture

// ===== ecidl_host_model.sv
// Host model that reaches the event registers by strobed reads and writes
`timescale 1ns/1ps
module ecidl_host_model (
  // Clock
  input  wire logic              clock_i,
  // Register port
  output ecidl_pkg::ecidl_addr_t addr_o,
  output logic                   wr_o,
  output logic                   rd_o,
  output ecidl_pkg::ecidl_byte_t wdata_o
);
  import ecidl_pkg::*;

  initial
  begin
    addr_o  = 7'h7f;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 8'h00;
  end

  // Flags are cleared by writing one to them only
  task automatic write_reg(input ecidl_addr_t a, input ecidl_byte_t d);
    @(negedge clock_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge clock_i);
    wr_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask : write_reg

  // Read strobe for one cycle; the bench checks the data
  task automatic read_reg(input ecidl_addr_t a);
    @(negedge clock_i);
    addr_o = a;
    rd_o   = 1'b1;
    @(negedge clock_i);
    rd_o   = 1'b0;
    addr_o = ~a;
  endtask : read_reg
endmodule : ecidl_host_model

// ===== ecidl_pin_edge.sv
// Edge detector for the local trigger pin
`timescale 1ns/1ps
module ecidl_pin_edge (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic reset_i,
  // Pin
  input  wire logic pin_i,
  // Edge pulses
  output logic      rise_o,
  output logic      fall_o
);
  logic prev;
  logic primed;
  logic next_prev;
  logic next_primed;
  logic next_rise;
  logic next_fall;

  always_comb
  begin
    next_prev   = pin_i;
    next_primed = 1'b1;
    next_rise   = primed && pin_i && !prev;
    next_fall   = primed && !pin_i && prev;
  end

  // First sample after reset only primes the history
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      prev   <= 1'b0;
      primed <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end
    else
    begin
      prev   <= next_prev;
      primed <= next_primed;
      rise_o <= next_rise;
      fall_o <= next_fall;
    end
  end
endmodule : ecidl_pin_edge

// ===== ecidl_pkg.sv
// Types shared by the event capture block
package ecidl_pkg;
  typedef logic [7:0] ecidl_byte_t;
  typedef logic [6:0] ecidl_addr_t;
  typedef enum logic [1:0]
  {
    ECIDL_TMR_IDLE = 2'b01,
    ECIDL_TMR_RUN  = 2'b10
  } ecidl_tmr_state_t;
endpackage : ecidl_pkg

// ===== ecidl_regs.svh
// Register offsets, field positions, reset values and timing for event capture
`ifndef ECIDL_REGS_SVH
`define ECIDL_REGS_SVH

`define ECIDL_ADDR_SYS_EN       7'h04
`define ECIDL_ADDR_BUS_EN       7'h23
`define ECIDL_ADDR_PIN_EN       7'h4c
`define ECIDL_ADDR_GLOBAL       7'h60
`define ECIDL_ADDR_SYS_FLAGS    7'h61
`define ECIDL_ADDR_BUS_FLAGS    7'h63
`define ECIDL_ADDR_PIN_FLAGS    7'h64

`define ECIDL_GLB_PIN_BIT       3
`define ECIDL_GLB_BUS_BIT       2
`define ECIDL_GLB_SYS_BIT       0

`define ECIDL_SYS_RESTART_BIT   4
`define ECIDL_SYS_OVERTEMP_BIT  2
`define ECIDL_SYS_SERIAL_BIT    1
`define ECIDL_BUS_FRAME_BIT     5
`define ECIDL_BUS_IDLE_BIT      4
`define ECIDL_BUS_FAULT_BIT     1
`define ECIDL_BUS_WAKEUP_BIT    0
`define ECIDL_PIN_RISE_BIT      1
`define ECIDL_PIN_FALL_BIT      0

`define ECIDL_SYS_FLAG_MASK     8'h16
`define ECIDL_BUS_FLAG_MASK     8'h33
`define ECIDL_PIN_FLAG_MASK     8'h03
`define ECIDL_SYS_EN_MASK       8'h06
`define ECIDL_BUS_EN_MASK       8'h13
`define ECIDL_PIN_EN_MASK       8'h03

`define ECIDL_SYS_FLAG_RESET    8'h10
`define ECIDL_BUS_FLAG_RESET    8'h00
`define ECIDL_PIN_FLAG_RESET    8'h00
`define ECIDL_EN_RESET          8'h00
`define ECIDL_UV_BUS_EN         8'h01
`define ECIDL_UV_PIN_EN         8'h03

`define ECIDL_MC_SLEEP          3'h1
`define ECIDL_BUS_MODE_UV       2'h1

`define ECIDL_CLK_PERIOD_NS     20
`define ECIDL_EVENT_DELAY_NS    100000
`define ECIDL_SILENCE_NS        1000000
`define ECIDL_EVENT_DELAY_CYC   ((`ECIDL_EVENT_DELAY_NS) / (`ECIDL_CLK_PERIOD_NS))
`define ECIDL_SILENCE_CYC       ((`ECIDL_SILENCE_NS) / (`ECIDL_CLK_PERIOD_NS))

`endif

// ===== event_capture_irq_delay_tb.sv
// Self-checking bench for the event capture block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module event_capture_irq_delay_tb;
  import ecidl_pkg::*;
  localparam int DLY = 8;
  localparam int SIL = 16;
  logic        clock_i, reset_i, reg_wr_i, reg_rd_i, mode_cmd_i;
  logic        normal_mode_i, bus_active_mode_i, bus_offline_i, normal_entered_i;
  logic        uv_forced_sleep_i, overtemp_i, serial_fault_i, frame_error_i, bus_wakeup_i;
  logic        bus_activity_i, txd_clamp_i, vcc_uv_i, wake_pin_i, rd_seen;
  logic        rx_alert_n_o, enter_sleep_o, enter_standby_o, normal_entry_flag_o;
  logic [1:0]  bus_mode_field_i;
  logic [2:0]  mode_control_field_i;
  ecidl_addr_t reg_addr_i;
  ecidl_byte_t reg_wdata_i, reg_rdata_o, v, note;
  logic [1:0]  mnote;
  int          errors, checked;
  logic [31:0] seed;
  ecidl_byte_t rd_q[$];
  logic [1:0]  mode_q[$];

  ecidl_event_capture #(.DELAY_CYCLES(DLY), .SILENCE_CYCLES(SIL)) i_ecidl_event_capture (
    .clock_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
    .normal_mode_i, .bus_active_mode_i, .bus_offline_i, .bus_mode_field_i, .mode_cmd_i,
    .mode_control_field_i, .normal_entered_i, .uv_forced_sleep_i, .overtemp_i,
    .serial_fault_i, .frame_error_i, .bus_wakeup_i, .bus_activity_i, .txd_clamp_i,
    .vcc_uv_i, .wake_pin_i, .rx_alert_n_o, .enter_sleep_o, .enter_standby_o,
    .normal_entry_flag_o);
  ecidl_host_model i_ecidl_host_model (.clock_i, .addr_o(reg_addr_i), .wr_o(reg_wr_i),
    .rd_o(reg_rd_i), .wdata_o(reg_wdata_i));

  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic print_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic rd(input ecidl_addr_t a, input ecidl_byte_t e);
    rd_q.push_back(e);
    i_ecidl_host_model.read_reg(a);
  endtask : rd

  task automatic wr(input ecidl_addr_t a, input ecidl_byte_t d);
    i_ecidl_host_model.write_reg(a, d);
  endtask : wr

  task automatic pulse(ref logic s);
    @(negedge clock_i);
    s = 1'b1;
    @(negedge clock_i);
    s = 1'b0;
  endtask : pulse

  task automatic idle(input int n);
    repeat (n) @(negedge clock_i);
  endtask : idle

  task automatic mode(input logic [2:0] f, input logic [1:0] e);
    if (f == 3'h1)
      mode_q.push_back(e);
    @(negedge clock_i);
    mode_control_field_i = f;
    mode_cmd_i = 1'b1;
    @(negedge clock_i);
    mode_cmd_i = 1'b0;
    idle(1);
  endtask : mode

  task automatic wait_alert_low;
    int n = 0;
    while (rx_alert_n_o !== 1'b0 && n < 12)
    begin
      @(negedge clock_i);
      n++;
    end
    `CHK("alert late", 1'b0, rx_alert_n_o)
  endtask : wait_alert_low

  // Monitor: each result takes the oldest note
  always @(posedge clock_i) rd_seen <= reg_rd_i;
  always @(negedge clock_i)
  begin
    if (rd_seen === 1'b1)
    begin
      note = (rd_q.size() > 0) ? rd_q.pop_front() : 8'h5a;
      `CHK("read data", note, reg_rdata_o)
    end
    if ((enter_sleep_o | enter_standby_o) === 1'b1)
    begin
      mnote = (mode_q.size() > 0) ? mode_q.pop_front() : 2'b11;
      `CHK("mode pulse", mnote, {enter_sleep_o, enter_standby_o})
    end
  end

  initial
  begin
    repeat (20000) @(posedge clock_i);
    errors++;
    $display("ERROR watchdog exp done got hang");
    print_verdict();
  end

  initial
  begin
    {reset_i, mode_cmd_i, bus_active_mode_i, normal_entered_i, uv_forced_sleep_i} = '0;
    {overtemp_i, serial_fault_i, frame_error_i, bus_wakeup_i, txd_clamp_i, vcc_uv_i} = '0;
    {wake_pin_i, bus_mode_field_i, mode_control_field_i} = '0;
    {normal_mode_i, bus_offline_i, bus_activity_i, reset_i} = 4'hf;
    {errors, checked} = '0;
    seed = 32'h34229965;
    idle(5);
    reset_i = 1'b0;
    idle(2);
    `CHK("entry flag", 1'b1, normal_entry_flag_o)
    `CHK("alert", 1'b0, rx_alert_n_o)
    rd(7'h61, 8'h10);
    rd(7'h60, 8'h01);
    rd(7'h63, 8'h00);
    rd(7'h64, 8'h00);
    rd(7'h04, 8'h00);
    rd(7'h7e, 8'h00);
    mode(3'h1, 2'b01);
    $display("test reset values done");
    for (int i = 0; i < 4; i++)
    begin
      v = ecidl_byte_t'(xs());
      wr(7'h04, v);
      rd(7'h04, v & 8'h06);
    end
    wr(7'h04, 8'h06);
    pulse(overtemp_i);
    rd(7'h61, 8'h14);
    wr(7'h61, 8'hf0);
    `CHK("alert", 1'b1, rx_alert_n_o)
    pulse(serial_fault_i);
    rd(7'h61, 8'h06);
    repeat (DLY - 4)
    begin
      @(negedge clock_i);
      `CHK("alert held", 1'b1, rx_alert_n_o)
    end
    wait_alert_low();
    wr(7'h61, 8'h00);
    rd(7'h61, 8'h06);
    `CHK("alert", 1'b0, rx_alert_n_o)
    wr(7'h61, 8'h06);
    `CHK("alert", 1'b1, rx_alert_n_o)
    idle(DLY + 4);
    `CHK("alert quiet", 1'b1, rx_alert_n_o)
    $display("test alert delay done");
    wr(7'h4c, 8'h03);
    wake_pin_i = 1'b1;
    idle(2);
    wake_pin_i = 1'b0;
    idle(2);
    rd(7'h64, 8'h03);
    wr(7'h64, 8'h00);
    rd(7'h64, 8'h03);
    rd(7'h60, 8'h08);
    pulse(bus_wakeup_i);
    wr(7'h23, 8'h13);
    bus_active_mode_i = 1'b1;
    normal_mode_i = 1'b0;
    pulse(txd_clamp_i);
    rd(7'h63, 8'h00);
    normal_mode_i = 1'b1;
    pulse(txd_clamp_i);
    pulse(frame_error_i);
    pulse(bus_wakeup_i);
    bus_activity_i = 1'b0;
    idle(SIL + 4);
    rd(7'h63, 8'h33);
    bus_activity_i = 1'b1;
    idle(2);
    wr(7'h63, 8'h10);
    rd(7'h63, 8'h23);
    wr(7'h63, 8'h02);
    pulse(vcc_uv_i);
    rd(7'h63, 8'h21);
    bus_mode_field_i = 2'h1;
    pulse(vcc_uv_i);
    rd(7'h63, 8'h23);
    rd(7'h60, 8'h0c);
    wait_alert_low();
    bus_offline_i = 1'b0;
    idle(2);
    `CHK("alert online", 1'b1, rx_alert_n_o)
    bus_offline_i = 1'b1;
    wr(7'h63, 8'hff);
    wr(7'h64, 8'hff);
    rd(7'h60, 8'h00);
    mode(3'h2, 2'b00);
    mode(3'h1, 2'b10);
    pulse(normal_entered_i);
    idle(1);
    `CHK("entry flag", 1'b0, normal_entry_flag_o)
    $display("test bus and mode done");
    reset_i = 1'b1;
    idle(5);
    reset_i = 1'b0;
    rd(7'h61, 8'h10);
    pulse(uv_forced_sleep_i);
    rd(7'h61, 8'h00);
    rd(7'h23, 8'h01);
    rd(7'h4c, 8'h03);
    idle(2);
    `CHK("notes left", 32'd0, rd_q.size() + mode_q.size())
    $display("test forced sleep done");
    print_verdict();
  end
endmodule : event_capture_irq_delay_tb
